// file: common/isr_pkg.sv
// Package for the status reporting block: command codes, bit positions,
// reset values and sizes.
// Assumes a single 10 MHz clock domain.
package isr_pkg;
  // Status byte bit positions.
  localparam int STB_MAV_BIT = 4;
  localparam int STB_ESB_BIT = 5;
  localparam int STB_MSS_BIT = 6;
  // Event status bit positions.
  localparam int ESR_OPC_BIT = 0;
  localparam int ESR_RQC_BIT = 1;
  localparam int ESR_QYE_BIT = 2;
  localparam int ESR_DDE_BIT = 3;
  localparam int ESR_EXE_BIT = 4;
  localparam int ESR_CME_BIT = 5;
  localparam int ESR_URQ_BIT = 6;
  localparam int ESR_PON_BIT = 7;
  // Output queue capacity in bytes.
  localparam int OQ_DEPTH = 75;
  // Reset values and the answer query byte.
  localparam logic [7:0] ESR_RESET = 8'h80;
  localparam logic [7:0] ENA_RESET = 8'h00;
  localparam logic [7:0] ASCII_ONE = 8'h31;
  // Bits of the event register that can ever be set.
  localparam logic [7:0] ESR_USED_MASK = 8'hBD;
  // Bits of the status byte that carry information.
  localparam logic [7:0] STB_USED_MASK = 8'h70;
  // Host command codes.
  typedef enum logic [3:0] {
    ISR_CMD_STB_Q = 4'h0,
    ISR_CMD_ESR_Q = 4'h1,
    ISR_CMD_SRE_W = 4'h2,
    ISR_CMD_SRE_Q = 4'h3,
    ISR_CMD_ESE_W = 4'h4,
    ISR_CMD_ESE_Q = 4'h5,
    ISR_CMD_OPC = 4'h6,
    ISR_CMD_OPC_Q = 4'h7,
    ISR_CMD_WAI = 4'h8,
    ISR_CMD_RST = 4'h9,
    ISR_CMD_NOP = 4'hF
  } isr_cmd_t;
  // Pending operation-complete request kind.
  typedef enum logic [1:0] {
    ISR_OPC_NONE = 2'b00,
    ISR_OPC_BIT = 2'b01,
    ISR_OPC_ANS = 2'b10
  } isr_opc_t;
endpackage : isr_pkg

// file: rtl/isr_oq_mem.sv
// Output queue storage for the status reporting block.
// Assumes one clock; writes and reads are qualified by the caller.
`timescale 1ns/10ps
module isr_oq_mem #(
  parameter int DEPTH = 75,
  parameter int AW = 7
) (
  // Clock.
  input wire logic clk,
  // Write side.
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [7:0] wr_data,
  // Read side, data registered.
  input wire logic rd_en,
  input wire logic [AW-1:0] rd_addr,
  output logic [7:0] rd_data_r
);
  logic [7:0] mem [DEPTH];

  // Storage array and registered read port.
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    if (rd_en) begin
      rd_data_r <= mem[rd_addr];
    end
  end
endmodule : isr_oq_mem

// file: rtl/isr_status.sv
// Status reporting and command synchronisation core: status byte, event
// register, enable masks, service request, output queue and wait handling.
// Assumes a command parser feeds one command per strobe and reports errors.
// Notes on behaviour
// - Message-available follows non-empty output queue.
// - Event summary from enabled event bits.
// - Master summary from enabled summary bits.
// - Copy status byte on master-summary change.
// - Raise SRQ on request flag; poll clears.
// - Unused status bits always read zero.
// - Operation complete set after pending work.
// - Request control bit always zero.
// - Query error on empty read or overflow.
// - Device error on fixed loop length.
// - Execution error on out-of-range parameter.
// - Command error on syntax, spelling, trigger.
// - User request bit always zero.
// - Power-on bit set at power-up only.
// - Event query queues value then clears.
// - Read, mask write, mask read per register.
// - Answer query queues ASCII one when done.
// - Wait stalls commands until work finishes.
// - Status query does not clear.
// - Power-on clear chooses clear or restore masks.
// - Level 3 reset cancels pending completion.
`timescale 1ns/10ps
module isr_status
  import isr_pkg::*;
#(
  parameter int DEPTH = isr_pkg::OQ_DEPTH
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Command strobe from the parser.
  input wire logic cmd_valid,
  input wire isr_pkg::isr_cmd_t cmd_code,
  input wire logic [7:0] cmd_data,
  output logic cmd_ready_r,
  // Error events from the parser and operation engine.
  input wire logic err_fixed_loop,
  input wire logic err_range,
  input wire logic err_syntax,
  input wire logic trigger_seen,
  input wire logic ops_busy,
  // Power-on clear value and stored masks.
  input wire logic psc_clear,
  input wire logic [7:0] nv_sre,
  input wire logic [7:0] nv_ese,
  // Output queue read by the controller.
  input wire logic oq_rd,
  output logic [7:0] oq_data_r,
  output logic oq_data_valid_r,
  // Serial poll and service request.
  input wire logic poll,
  output logic [7:0] poll_byte_r,
  output logic srq_r,
  output logic [7:0] stb_r,
  output logic [7:0] esr_r
);
  localparam int AW = $clog2(DEPTH + 1);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
  localparam logic [AW-1:0] FULL = AW'(DEPTH);

  logic [7:0] esr_nxt, sre_r, sre_nxt, ese_r, ese_nxt, stb_nxt, poll_byte_nxt;
  logic srq_nxt, mss_r, mss_nxt, cmd_ready_nxt, oq_data_valid_nxt;
  logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt, cnt_r, cnt_nxt;
  isr_opc_t opc_r, opc_nxt;
  logic wai_r, wai_nxt, init_r;
  logic push, pop, do_cmd;
  logic [7:0] push_data, mem_q;
  logic mav, esb, mss;
  logic [7:0] stb_now;

  // Summary bits, combinational from masked values.
  always_comb begin
    mav = (cnt_r != '0);
    esb = |(esr_r & ese_r);
    stb_now = 8'h00;
    stb_now[STB_MAV_BIT] = mav;
    stb_now[STB_ESB_BIT] = esb;
    mss = |(stb_now & sre_r & STB_USED_MASK);
    stb_now[STB_MSS_BIT] = mss;
  end

  // Command acceptance is blocked while a wait is in force.
  assign do_cmd = cmd_valid && cmd_ready_r && init_r;

  // Next state for registers, queue pointers and synchronisation.
  always_comb begin
    esr_nxt = esr_r;
    sre_nxt = sre_r;
    ese_nxt = ese_r;
    opc_nxt = opc_r;
    wai_nxt = wai_r;
    push = 1'b0;
    push_data = 8'h00;
    pop = 1'b0;
    oq_data_valid_nxt = 1'b0;
    if (!init_r) begin
      // first cycle after reset picks clear or restore.
      sre_nxt = psc_clear ? ENA_RESET : nv_sre;
      ese_nxt = psc_clear ? ENA_RESET : nv_ese;
    end
    if (do_cmd) begin
      case (cmd_code)
        ISR_CMD_STB_Q: begin
          push = 1'b1;
          push_data = stb_now;
        end
        ISR_CMD_ESR_Q: begin
          push = 1'b1;
          push_data = esr_r;
          esr_nxt = 8'h00;
        end
        ISR_CMD_SRE_W: sre_nxt = cmd_data;
        ISR_CMD_SRE_Q: begin
          push = 1'b1;
          push_data = sre_r;
        end
        ISR_CMD_ESE_W: ese_nxt = cmd_data;
        ISR_CMD_ESE_Q: begin
          push = 1'b1;
          push_data = ese_r;
        end
        ISR_CMD_OPC: opc_nxt = ISR_OPC_BIT;
        ISR_CMD_OPC_Q: opc_nxt = ISR_OPC_ANS;
        ISR_CMD_WAI: wai_nxt = 1'b1;
        ISR_CMD_RST: opc_nxt = ISR_OPC_NONE;
        default: ;
      endcase
    end
    // Completion of pending work.
    if (opc_r != ISR_OPC_NONE && !ops_busy && !(do_cmd && cmd_code == ISR_CMD_RST)) begin
      opc_nxt = ISR_OPC_NONE;
      if (opc_r == ISR_OPC_BIT) begin
        esr_nxt[ESR_OPC_BIT] = 1'b1;
      end else if (!push) begin
        push = 1'b1;
        push_data = ASCII_ONE;
      end else begin
        opc_nxt = opc_r; // Retry next cycle.
      end
    end
    if (wai_r && !ops_busy) begin
      wai_nxt = 1'b0;
    end
    // Controller read of the queue.
    if (oq_rd) begin
      if (cnt_r == '0) begin
        esr_nxt[ESR_QYE_BIT] = 1'b1;
      end else begin
        pop = 1'b1;
        oq_data_valid_nxt = 1'b1;
      end
    end
    if (push && cnt_r == FULL && !pop) begin
      esr_nxt[ESR_QYE_BIT] = 1'b1;
      push = 1'b0;
    end
    // Error events set bits; sets win over the query clear.
    if (err_fixed_loop) esr_nxt[ESR_DDE_BIT] = 1'b1;
    if (err_range) esr_nxt[ESR_EXE_BIT] = 1'b1;
    if (err_syntax || trigger_seen) esr_nxt[ESR_CME_BIT] = 1'b1;
    esr_nxt = esr_nxt & ESR_USED_MASK;
    wp_nxt = push ? ((wp_r == LAST) ? '0 : wp_r + 1'b1) : wp_r;
    rp_nxt = pop ? ((rp_r == LAST) ? '0 : rp_r + 1'b1) : rp_r;
    cnt_nxt = cnt_r + AW'(push) - AW'(pop);
    cmd_ready_nxt = !wai_nxt && !(do_cmd && cmd_code == ISR_CMD_WAI);
  end

  // Serial poll interface: copy on change, poll clears request.
  always_comb begin
    mss_nxt = mss;
    poll_byte_nxt = poll_byte_r;
    srq_nxt = srq_r;
    stb_nxt = stb_now;
    if (mss != mss_r) begin
      poll_byte_nxt = stb_now;
      srq_nxt = mss;
    end
    if (poll) begin
      poll_byte_nxt[STB_MSS_BIT] = 1'b0;
      srq_nxt = 1'b0;
    end
  end

  // Register all state.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      esr_r <= ESR_RESET;
      sre_r <= ENA_RESET;
      ese_r <= ENA_RESET;
      opc_r <= ISR_OPC_NONE;
      wai_r <= 1'b0;
      init_r <= 1'b0;
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
      cmd_ready_r <= 1'b0;
      oq_data_valid_r <= 1'b0;
      mss_r <= 1'b0;
      poll_byte_r <= 8'h00;
      srq_r <= 1'b0;
      stb_r <= 8'h00;
    end else begin
      esr_r <= esr_nxt;
      sre_r <= sre_nxt;
      ese_r <= ese_nxt;
      opc_r <= opc_nxt;
      wai_r <= wai_nxt;
      init_r <= 1'b1;
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
      cmd_ready_r <= cmd_ready_nxt;
      oq_data_valid_r <= oq_data_valid_nxt;
      mss_r <= mss_nxt;
      poll_byte_r <= poll_byte_nxt;
      srq_r <= srq_nxt;
      stb_r <= stb_nxt;
    end
  end

  // Output queue storage; read data is registered inside.
  isr_oq_mem #(.DEPTH(DEPTH), .AW(AW)) u_mem (
    .clk(clk),
    .wr_en(push),
    .wr_addr(wp_r),
    .wr_data(push_data),
    .rd_en(pop),
    .rd_addr(rp_r),
    .rd_data_r(mem_q)
  );
  assign oq_data_r = mem_q;

  // Checks.
  property p_mav;
    @(posedge clk) disable iff (!rst_n) ##1 (stb_r[STB_MAV_BIT] == ($past(cnt_r) != '0));
  endproperty
  a_mav: assert property (p_mav) else $error("MAV mismatch");
  property p_esb;
    @(posedge clk) disable iff (!rst_n) ##1 stb_r[STB_ESB_BIT] == |($past(esr_r) & $past(ese_r));
  endproperty
  a_esb: assert property (p_esb) else $error("ESB mismatch");
  property p_unused;
    @(posedge clk) disable iff (!rst_n) (stb_r & ~STB_USED_MASK) == 8'h00;
  endproperty
  a_unused: assert property (p_unused) else $error("unused status bit set");
  property p_rqc;
    @(posedge clk) disable iff (!rst_n) !esr_r[ESR_RQC_BIT] && !esr_r[ESR_URQ_BIT];
  endproperty
  a_rqc: assert property (p_rqc) else $error("fixed-zero event bit set");
  property p_srq;
    @(posedge clk) disable iff (!rst_n) poll |=> !srq_r && !poll_byte_r[STB_MSS_BIT];
  endproperty
  a_srq: assert property (p_srq) else $error("poll did not clear SRQ");
  property p_qye;
    @(posedge clk) disable iff (!rst_n) (oq_rd && cnt_r == '0) |=> esr_r[ESR_QYE_BIT];
  endproperty
  a_qye: assert property (p_qye) else $error("empty read without query error");
  property p_cme;
    @(posedge clk) disable iff (!rst_n) (err_syntax || trigger_seen) |=> esr_r[ESR_CME_BIT];
  endproperty
  a_cme: assert property (p_cme) else $error("command error not set");
  property p_exe;
    @(posedge clk) disable iff (!rst_n) err_range |=> esr_r[ESR_EXE_BIT];
  endproperty
  a_exe: assert property (p_exe) else $error("execution error not set");
  property p_wai;
    @(posedge clk) disable iff (!rst_n) (wai_r && ops_busy) |=> !cmd_ready_r;
  endproperty
  a_wai: assert property (p_wai) else $error("wait did not stall");
  c_srq: cover property (@(posedge clk) disable iff (!rst_n) $rose(srq_r));
  c_opc: cover property (@(posedge clk) disable iff (!rst_n) $rose(esr_r[ESR_OPC_BIT]));
  c_wai: cover property (@(posedge clk) disable iff (!rst_n) $fell(cmd_ready_r));
endmodule : isr_status

// file: testbench/isr_ctl_model.sv
// Controller model: drains the output queue and answers service requests.
// Assumes the status core settles its outputs before each falling edge.
`timescale 1ns/10ps
module isr_ctl_model (
  // Clock and controls from the bench.
  input wire logic clk,
  input wire logic drain,
  input wire logic slow,
  input wire logic rd_now,
  input wire logic poll_en,
  // Core status.
  input wire logic [7:0] stb_r,
  input wire logic srq_r,
  // Controller strobes.
  output logic oq_rd,
  output logic poll
);
  int gap;
  initial begin
    oq_rd = 1'b0;
    poll = 1'b0;
  end
  // Reads one byte per pulse; the pause covers the late status byte.
  always begin
    @(negedge clk);
    if ((drain && stb_r[isr_pkg::STB_MAV_BIT]) || rd_now) begin
      oq_rd <= 1'b1;
      @(negedge clk);
      oq_rd <= 1'b0;
      gap = slow ? $urandom_range(6, 2) : 2;
      repeat (gap) @(negedge clk);
    end
  end
  // Serial poll once per service request.
  always @(negedge clk) poll <= poll_en && srq_r && !poll;
endmodule : isr_ctl_model

// file: testbench/ieee4882_status_reporting_bench.sv
// Self-checking bench for the status core with a controller model.
// Assumes the core answers queries with single binary bytes.
`timescale 1ns/10ps
module ieee4882_status_reporting_bench;
  import isr_pkg::*;
  logic clk, rst_n, cmd_valid, cmd_ready_r, ops_busy, psc_clear, oq_rd, poll;
  logic drain, slow, rd_now, poll_en, oq_data_valid_r, srq_r;
  isr_cmd_t cmd_code;
  logic [3:0] errs;
  logic [7:0] cmd_data, nv_sre, nv_ese, oq_data_r, poll_byte_r, stb_r, esr_r, ex;
  logic [7:0] exp_q[$];
  int n_fail, checks_done, cyc;
  isr_status u_isr_status (.clk, .rst_n, .cmd_valid, .cmd_code, .cmd_data, .cmd_ready_r,
    .err_fixed_loop(errs[0]), .err_range(errs[1]), .err_syntax(errs[2]),
    .trigger_seen(errs[3]), .ops_busy, .psc_clear, .nv_sre, .nv_ese, .oq_rd,
    .oq_data_r, .oq_data_valid_r, .poll, .poll_byte_r, .srq_r, .stb_r, .esr_r);
  isr_ctl_model u_isr_ctl_model (.clk, .drain, .slow, .rd_now, .poll_en, .stb_r, .srq_r,
    .oq_rd, .poll);
  // Clock generator.
  always #50 clk = ~clk;
  task automatic end_sim();
    $display("checks %0d failures %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask : idle
  // Offers a command and holds it until the core takes it.
  task automatic cmd(input isr_cmd_t c, input logic [7:0] d);
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd_code = c;
    cmd_data = d;
    while (cmd_ready_r !== 1'b1) @(negedge clk);
    @(negedge clk);
    cmd_valid = 1'b0;
  endtask : cmd
  task automatic qry(input isr_cmd_t c, input logic [7:0] e);
    exp_q.push_back(e);
    cmd(c, 8'h00);
  endtask : qry
  // Watches queue reads and compares with the oldest expected byte.
  always @(negedge clk) begin
    if (oq_data_valid_r === 1'b1) begin
      if (exp_q.size() == 0)
        chk(oq_data_r, 8'hxx, "unexpected byte");
      else
        chk(oq_data_r, exp_q.pop_front(), "queue byte");
    end
  end
  // Cuts a hang short.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      $display("Error %0t: timeout", $time);
      end_sim();
    end
  end
  initial begin
    {clk, rst_n, cmd_valid, ops_busy, psc_clear, drain, slow, rd_now, poll_en} = '0;
    {errs, cmd_data, n_fail, checks_done, cyc} = '0;
    {nv_sre, nv_ese} = {8'h20, 8'h80};
    cmd_code = ISR_CMD_NOP;
    void'($urandom(32'h48cb_5ea6));
    repeat (3) @(posedge clk);
    chk(esr_r, 8'h80, "esr in reset");
    @(negedge clk);
    rst_n = 1'b1;
    idle(4);
    chk(stb_r, 8'h60, "restored summary");
    chk(poll_byte_r, 8'h60, "bus byte");
    chk({7'h0, srq_r}, 8'h01, "srq up");
    poll_en = 1'b1;
    idle(3);
    chk({poll_byte_r[6], 6'h0, srq_r}, 8'h00, "poll clears");
    {poll_en, drain, slow} = 3'b111;
    $display("test power_on done");
    qry(ISR_CMD_SRE_Q, 8'h20);
    qry(ISR_CMD_ESE_Q, 8'h80);
    qry(ISR_CMD_ESR_Q, 8'h80);
    idle(30);
    chk(esr_r, 8'h00, "esr cleared");
    drain = 1'b0;
    qry(ISR_CMD_ESR_Q, 8'h00);
    idle(4);
    qry(ISR_CMD_STB_Q, 8'h10);
    idle(4);
    qry(ISR_CMD_STB_Q, 8'h10);
    drain = 1'b1;
    idle(30);
    $display("test queries done");
    cmd(ISR_CMD_ESE_W, 8'h3d);
    for (int i = 0; i < 6; i++) begin
      @(negedge clk);
      errs = 4'($urandom_range(15, 1));
      ex = {2'b00, errs[2] | errs[3], errs[1], errs[0], 3'b000};
      @(negedge clk);
      errs = 4'h0;
      idle(3);
      chk(esr_r, ex, "error events");
      chk(stb_r, 8'h60, "event summary");
      qry(ISR_CMD_ESR_Q, ex);
      idle(20);
    end
    $display("test events done");
    ops_busy = 1'b1;
    cmd(ISR_CMD_OPC, 8'h00);
    idle(5);
    chk(esr_r, 8'h00, "opc early");
    ops_busy = 1'b0;
    idle(3);
    chk(esr_r, 8'h01, "opc done");
    qry(ISR_CMD_ESR_Q, 8'h01);
    ops_busy = 1'b1;
    cmd(ISR_CMD_OPC, 8'h00);
    cmd(ISR_CMD_RST, 8'h00);
    ops_busy = 1'b0;
    idle(20);
    chk(esr_r, 8'h00, "reset cancels");
    cmd(ISR_CMD_SRE_W, 8'h10);
    // Polling stops here so that the raised request stays visible.
    {drain, ops_busy, poll_en} = 3'b010;
    cmd(ISR_CMD_OPC_Q, 8'h00);
    idle(5);
    chk(stb_r, 8'h00, "opcq early");
    exp_q.push_back(8'h31);
    ops_busy = 1'b0;
    idle(5);
    chk({stb_r[6:0], srq_r}, 8'ha1, "opcq answer");
    chk(esr_r, 8'h00, "opcq no bit");
    drain = 1'b1;
    idle(20);
    $display("test sync done");
    ops_busy = 1'b1;
    cmd(ISR_CMD_WAI, 8'h00);
    idle(3);
    chk({7'h0, cmd_ready_r}, 8'h00, "wait stalls");
    ops_busy = 1'b0;
    idle(3);
    chk({cmd_ready_r, esr_r[6:0]}, 8'h80, "wait ends");
    drain = 1'b0;
    rd_now = 1'b1;
    idle(2);
    rd_now = 1'b0;
    idle(3);
    chk(esr_r, 8'h04, "empty read");
    drain = 1'b1;
    qry(ISR_CMD_ESR_Q, 8'h04);
    idle(20);
    drain = 1'b0;
    for (int i = 0; i < 76; i++) begin
      if (i < OQ_DEPTH)
        qry(ISR_CMD_SRE_Q, 8'h10);
      else
        cmd(ISR_CMD_SRE_Q, 8'h00);
    end
    idle(3);
    chk(esr_r, 8'h04, "overflow");
    drain = 1'b1;
    idle(700);
    chk(8'(exp_q.size()), 8'h00, "queue drained");
    $display("test queue done");
    end_sim();
  end
endmodule : ieee4882_status_reporting_bench
